//--- core/mcp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_params.svh"

module mcp_core (
   input  wire logic        clk_i,      // 125 MHz peripheral clock
   input  wire logic        srst_i,     // sync reset, active high
   input  wire logic        pclk_en_i,  // peripheral clock enable from power manager
   input  wire logic [7:0]  addr_i,     // register byte address
   input  wire logic [31:0] wdata_i,    // write data
   input  wire logic        we_i,       // write strobe
   input  wire logic        re_i,       // read strobe
   input  wire logic [3:0]  fault_i,    // per-channel fault inputs
   output logic [31:0]      rdata_o,    // read data, cycle after re_i
   output logic [3:0]       final_high_side_pin_o, // high-side pins
   output logic [3:0]       final_low_side_pin_o,  // low-side pins
   output logic [3:0]       gray_o,     // {pair1, pair0} gray codes
   output logic             irq_o       // level interrupt
);
   import mcp_pkg::*;

   mcp_state_s st_reg;
   mcp_state_s st_next;

   function automatic logic ptick(input logic [9:0] pc, input logic [3:0] n, input logic en);
      logic [9:0] m;
      m = 10'((11'h001 << n) - 11'h001);
      return en && ((pc & m) == m);
   endfunction : ptick

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic       t;
      logic       ps;
      logic       wn;
      logic       dh;
      logic       dl;
      logic [1:0] b;
      logic [2:0] ci;
      mcp_cnt_t   cc;
      st_next = st_reg;
      t = 1'b0;
      ps = 1'b0;
      wn = 1'b0;
      dh = 1'b0;
      dl = 1'b0;
      b = 2'h0;
      cc = 16'h0000;
      ci = 3'(addr_i[6:4] - 3'h2);
      // free-running 10-bit prescaler; tap n divides by 2^n
      if (pclk_en_i) begin
         st_next.pre_cnt = 10'(st_reg.pre_cnt + 10'h001);
      end
      // aux divided clocks; divider zero keeps them off
      st_next.tick_a = 1'b0;
      st_next.tick_b = 1'b0;
      if (st_reg.div_a != 8'h00 && st_reg.pre_a < `MCP_NDIV
          && ptick(st_reg.pre_cnt, st_reg.pre_a, pclk_en_i)) begin
         if (8'(st_reg.acnt_a + 8'h01) >= st_reg.div_a) begin
            st_next.acnt_a = 8'h00;
            st_next.tick_a = 1'b1;
         end else begin
            st_next.acnt_a = 8'(st_reg.acnt_a + 8'h01);
         end
      end
      if (st_reg.div_b != 8'h00 && st_reg.pre_b < `MCP_NDIV
          && ptick(st_reg.pre_cnt, st_reg.pre_b, pclk_en_i)) begin
         if (8'(st_reg.acnt_b + 8'h01) >= st_reg.div_b) begin
            st_next.acnt_b = 8'h00;
            st_next.tick_b = 1'b1;
         end else begin
            st_next.acnt_b = 8'(st_reg.acnt_b + 8'h01);
         end
      end
      // register writes
      if (we_i) begin
         case (addr_i)
            `MCP_A_CLK: begin
               st_next.div_a = wdata_i[7:0];
               st_next.pre_a = wdata_i[11:8];
               st_next.div_b = wdata_i[23:16];
               st_next.pre_b = wdata_i[27:24];
            end
            `MCP_A_SYNC: st_next.sync = wdata_i[3:0];
            `MCP_A_ENA:  st_next.ena  = wdata_i[3:0];
            `MCP_A_OVR:  st_next.ovr  = wdata_i[15:0];
            `MCP_A_FLT:  st_next.flt  = wdata_i[11:0];
            `MCP_A_ISR:  st_next.isr  = st_reg.isr & ~wdata_i[4:0];
            `MCP_A_IMR:  st_next.imr  = wdata_i[4:0];
            `MCP_A_GRAY: st_next.gcfg = wdata_i[3:0];
            default: begin
               if (addr_i >= `MCP_A_CH0 && addr_i <= `MCP_A_CHEND) begin
                  case (addr_i[3:2])
                     `MCP_R_MODE: begin
                        st_next.csel[ci[1:0]] = wdata_i[3:0];
                        st_next.calg[ci[1:0]] = wdata_i[8];
                        st_next.cpol[ci[1:0]] = wdata_i[9];
                     end
                     `MCP_R_PRD: st_next.prd[ci[1:0]] = wdata_i[15:0];
                     `MCP_R_DTY: st_next.dty[ci[1:0]] = wdata_i[15:0];
                     default: begin
                        st_next.dth_p[ci[1:0]] = wdata_i[11:0];
                        st_next.dtl_p[ci[1:0]] = wdata_i[27:16];
                     end
                  endcase
               end
            end
         endcase
      end
      // channels
      for (int i = 0; i < `MCP_NCH; i++) begin
         if (st_reg.csel[i] < `MCP_NDIV) begin
            t = ptick(st_reg.pre_cnt, st_reg.csel[i], pclk_en_i);
         end else if (st_reg.csel[i] == `MCP_SEL_A) begin
            t = st_reg.tick_a;
         end else begin
            t = (st_reg.csel[i] == `MCP_SEL_B) && st_reg.tick_b;
         end
         t = t && st_reg.ena[i];
         ps = 1'b0;
         cc = st_reg.sync[i] ? st_reg.cnt[0] : st_reg.cnt[i];
         if (t) begin
            if (st_reg.calg[i]) begin
               if (st_reg.cdir[i]) begin
                  if (st_reg.cnt[i] == 16'h0000) begin
                     st_next.cdir[i] = 1'b0;
                     st_next.cnt[i] = 16'h0001;
                     ps = 1'b1;
                  end else begin
                     st_next.cnt[i] = 16'(st_reg.cnt[i] - 16'h0001);
                  end
               end else if (st_reg.cnt[i] >= st_reg.prd[i]) begin
                  st_next.cdir[i] = 1'b1;
                  st_next.cnt[i] = 16'(st_reg.cnt[i] - 16'h0001);
               end else begin
                  st_next.cnt[i] = 16'(st_reg.cnt[i] + 16'h0001);
               end
            end else if (st_reg.cnt[i] >= st_reg.prd[i]) begin
               st_next.cnt[i] = 16'h0000;
               ps = 1'b1;
            end else begin
               st_next.cnt[i] = 16'(st_reg.cnt[i] + 16'h0001);
            end
            if (ps) begin
               st_next.dth[i] = st_reg.dth_p[i];
               st_next.dtl[i] = st_reg.dtl_p[i];
               st_next.isr[i] = 1'b1;
            end
            wn = (cc < st_reg.dty[i]) ^ st_reg.cpol[i];
            if (wn != st_reg.wave[i]) begin
               st_next.wave[i] = wn;
               st_next.dtc[i] = wn ? st_reg.dth[i] : st_reg.dtl[i];
               st_next.dt_h[i] = 1'b0;
               st_next.dt_l[i] = 1'b0;
            end else if (st_reg.dtc[i] != 12'h000) begin
               st_next.dtc[i] = 12'(st_reg.dtc[i] - 12'h001);
            end else begin
               st_next.dt_h[i] = st_reg.wave[i];
               st_next.dt_l[i] = ~st_reg.wave[i];
            end
         end
         dh = st_reg.ovr[i] ? st_reg.ovr[8+i] : st_next.dt_h[i];
         dl = st_reg.ovr[4+i] ? st_reg.ovr[12+i] : st_next.dt_l[i];
         if (st_reg.flt[8+i] && fault_i[i]) begin
            dh = st_reg.flt[i];
            dl = st_reg.flt[4+i];
            st_next.isr[`MCP_FLT_BIT] = 1'b1;
         end
         st_next.pin_h[i] = dh;
         st_next.pin_l[i] = dl;
         // gray counter advances on even channel period start
         if (i % 2 == 0 && ps && st_reg.gcfg[i/2]) begin
            b = {st_reg.gray[i/2][1], st_reg.gray[i/2][1] ^ st_reg.gray[i/2][0]};
            b = st_reg.gcfg[2+i/2] ? 2'(b - 2'h1) : 2'(b + 2'h1);
            st_next.gray[i/2] = {b[1], b[1] ^ b[0]};
         end
      end
      st_next.irq = |(st_next.isr & st_next.imr);
      // read port
      st_next.rdata = 32'h0000_0000;
      if (re_i) begin
         case (addr_i)
            `MCP_A_CLK:  st_next.rdata = {4'h0, st_reg.pre_b, st_reg.div_b, 4'h0, st_reg.pre_a, st_reg.div_a};
            `MCP_A_SYNC: st_next.rdata = {28'h0, st_reg.sync};
            `MCP_A_ENA:  st_next.rdata = {28'h0, st_reg.ena};
            `MCP_A_OVR:  st_next.rdata = {16'h0, st_reg.ovr};
            `MCP_A_FLT:  st_next.rdata = {16'h0, fault_i, st_reg.flt};
            `MCP_A_ISR:  st_next.rdata = {27'h0, st_reg.isr};
            `MCP_A_IMR:  st_next.rdata = {27'h0, st_reg.imr};
            `MCP_A_GRAY: st_next.rdata = {24'h0, st_reg.gray, st_reg.gcfg};
            default: begin
               if (addr_i >= `MCP_A_CH0 && addr_i <= `MCP_A_CHEND) begin
                  case (addr_i[3:2])
                     `MCP_R_MODE: st_next.rdata = {22'h0, st_reg.cpol[ci[1:0]], st_reg.calg[ci[1:0]],
                                                   4'h0, st_reg.csel[ci[1:0]]};
                     `MCP_R_PRD:  st_next.rdata = {16'h0, st_reg.prd[ci[1:0]]};
                     `MCP_R_DTY:  st_next.rdata = {16'h0, st_reg.dty[ci[1:0]]};
                     default:     st_next.rdata = {16'h0, st_reg.cnt[ci[1:0]]};
                  endcase
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata_o = st_reg.rdata;
   assign final_high_side_pin_o = st_reg.pin_h;
   assign final_low_side_pin_o = st_reg.pin_l;
   assign gray_o = {st_reg.gray[1], st_reg.gray[0]};
   assign irq_o = st_reg.irq;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   AST_AUX_OFF: assert property ($fell(srst_i) |-> st_reg.div_a == 8'h00 && !st_reg.tick_a)
      else $error("aux clock not off after reset");
   AST_GATED: assert property (!pclk_en_i && !st_reg.tick_a && !st_reg.tick_b |=> $stable(st_reg.cnt))
      else $error("counter moved while clock gated");
   AST_CNT_UP: assert property (st_reg.ena[0] && !st_reg.calg[0] && st_reg.csel[0] == 4'h0 && pclk_en_i
                                && st_reg.cnt[0] < st_reg.prd[0] |=> st_reg.cnt[0] == $past(st_reg.cnt[0]) + 16'h0001)
      else $error("counter did not increment");
   AST_FOLLOW: assert property (st_reg.sync[1] && st_reg.ena[1] && st_reg.csel[1] == 4'h0 && pclk_en_i
                                |=> st_reg.wave[1] == (($past(st_reg.cnt[0]) < $past(st_reg.dty[1])) ^ $past(st_reg.cpol[1])))
      else $error("comparator did not follow channel 0");
   AST_NO_SHOOT: assert property (!(|(st_reg.dt_h & st_reg.dt_l)))
      else $error("dead-time outputs both high");
   AST_OVERRIDE: assert property (st_reg.ovr[0] && !(st_reg.flt[8] && fault_i[0])
                                  |=> final_high_side_pin_o[0] == $past(st_reg.ovr[8]))
      else $error("override level not applied");
   AST_FAULT: assert property (st_reg.flt[8] && fault_i[0] |=> final_high_side_pin_o[0] == $past(st_reg.flt[0])
                               && final_low_side_pin_o[0] == $past(st_reg.flt[4]))
      else $error("fault levels not forced");
   AST_DT_PERIOD: assert property (!$stable(st_reg.dth[0]) |-> st_reg.cnt[0] <= 16'h0001)
      else $error("dead time changed mid period");
   AST_DT_LOW12: assert property (we_i && addr_i == 8'h2C |=> st_reg.dth_p[0] == $past(wdata_i[11:0])
                                  && st_reg.dtl_p[0] == $past(wdata_i[27:16]))
      else $error("dead-time update not captured");
   AST_GRAY: assert property ($countones(st_reg.gray[0] ^ $past(st_reg.gray[0])) <= 1)
      else $error("gray counter changed two bits");
endmodule : mcp_core
`default_nettype wire

//--- shared/mcp_params.svh
`ifndef MCP_PARAMS_SVH
`define MCP_PARAMS_SVH
`define MCP_NCH     4
`define MCP_A_CLK   8'h00
`define MCP_A_SYNC  8'h04
`define MCP_A_ENA   8'h08
`define MCP_A_OVR   8'h0C
`define MCP_A_FLT   8'h10
`define MCP_A_ISR   8'h14
`define MCP_A_IMR   8'h18
`define MCP_A_GRAY  8'h1C
`define MCP_A_CH0   8'h20
`define MCP_A_CHEND 8'h5F
`define MCP_R_MODE  2'h0
`define MCP_R_PRD   2'h1
`define MCP_R_DTY   2'h2
`define MCP_R_DTUPD 2'h3
`define MCP_NDIV    4'hB
`define MCP_SEL_A   4'hB
`define MCP_SEL_B   4'hC
`define MCP_FLT_BIT 4
`endif

//--- shared/mcp_pkg.sv
package mcp_pkg;
   typedef logic [15:0] mcp_cnt_t;
   typedef logic [11:0] mcp_dt_t;
   typedef struct packed {
      logic [9:0]      pre_cnt;
      logic [7:0]      div_a;
      logic [7:0]      div_b;
      logic [3:0]      pre_a;
      logic [3:0]      pre_b;
      logic [7:0]      acnt_a;
      logic [7:0]      acnt_b;
      logic            tick_a;
      logic            tick_b;
      logic [3:0]      sync;
      logic [3:0]      ena;
      logic [15:0]     ovr;
      logic [11:0]     flt;
      logic [4:0]      isr;
      logic [4:0]      imr;
      logic [3:0]      gcfg;
      logic [1:0][1:0] gray;
      logic [3:0][3:0] csel;
      logic [3:0]      calg;
      logic [3:0]      cpol;
      logic [3:0]      cdir;
      mcp_cnt_t [3:0]  cnt;
      mcp_cnt_t [3:0]  prd;
      mcp_cnt_t [3:0]  dty;
      mcp_dt_t [3:0]   dth;
      mcp_dt_t [3:0]   dtl;
      mcp_dt_t [3:0]   dth_p;
      mcp_dt_t [3:0]   dtl_p;
      mcp_dt_t [3:0]   dtc;
      logic [3:0]      wave;
      logic [3:0]      dt_h;
      logic [3:0]      dt_l;
      logic [3:0]      pin_h;
      logic [3:0]      pin_l;
      logic            irq;
      logic [31:0]     rdata;
   } mcp_state_s;
endpackage : mcp_pkg

//--- test/mcp_power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_power_stage_model (
   input  wire logic [3:0] high_i,  // high-side switch gates
   input  wire logic [3:0] low_i,   // low-side switch gates
   input  wire logic       clk_i,   // peripheral clock
   output logic [31:0]     shoot_o, // cycles with both switches on
   output logic [31:0]     gap0_o,  // last both-off run, channel 0
   output logic [31:0]     rise1_o  // high-side turn-ons, channel 1
);
   logic [31:0] run_reg;
   logic        h1_reg;
   initial begin
      shoot_o = 0;
      gap0_o = 0;
      rise1_o = 0;
      run_reg = 0;
      h1_reg = 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      if ((high_i & low_i) != 4'h0) shoot_o <= shoot_o + 1;
      if (!high_i[0] && !low_i[0]) begin
         run_reg <= run_reg + 1;
      end else begin
         if (run_reg != 0) gap0_o <= run_reg;
         run_reg <= 0;
      end
      h1_reg <= high_i[1];
      if (high_i[1] && !h1_reg) rise1_o <= rise1_o + 1;
   end
endmodule : mcp_power_stage_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_params.svh"
module tb_top;
   logic        clk_i;
   logic        srst_i;
   logic        pclk_en_i;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i;
   logic        we_i;
   logic        re_i;
   logic [3:0]  fault_i;
   logic [31:0] rdata_o;
   logic [3:0]  hi_o;
   logic [3:0]  lo_o;
   logic [3:0]  gray_o;
   logic        irq_o;
   logic [31:0] shoot;
   logic [31:0] gap0;
   logic [31:0] rise1;
   logic [31:0] v;
   logic [31:0] w;
   logic [31:0] x;
   int          err_total;
   int          checks_done;
   int          i;
   mcp_core DUT (.clk_i(clk_i), .srst_i(srst_i), .pclk_en_i(pclk_en_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .fault_i(fault_i), .rdata_o(rdata_o),
      .final_high_side_pin_o(hi_o), .final_low_side_pin_o(lo_o), .gray_o(gray_o), .irq_o(irq_o));
   mcp_power_stage_model stage (.high_i(hi_o), .low_i(lo_o), .clk_i(clk_i),
      .shoot_o(shoot), .gap0_o(gap0), .rise1_o(rise1));
   always #4 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask : rd
   task automatic timeout(input int n);
      if (n == 500) begin
         err_total++;
         end_sim();
      end
   endtask : timeout
   // counter and pins must stand still
   task automatic hold_check;
      rd(8'h2C, v);
      w = {24'h0, hi_o, lo_o};
      cyc(6);
      rd(8'h2C, x);
      chk(x, v);
      chk({24'h0, hi_o, lo_o}, w);
   endtask : hold_check
   task automatic wait_gray(input logic [1:0] old);
      for (i = 0; i < 500 && gray_o[1:0] === old; i++) cyc(1);
      timeout(i);
   endtask : wait_gray
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 0;
      srst_i = 1;
      pclk_en_i = 1;
      addr_i = 0;
      wdata_i = 0;
      we_i = 0;
      re_i = 0;
      fault_i = 0;
      err_total = 0;
      checks_done = 0;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(`MCP_A_CLK, v);
      chk(v, 32'h0);
      chk({24'h0, hi_o, lo_o}, 32'h0);
      rd(8'h60, v);
      chk(v, 32'h0);
      // aux clock A selected while its divider is still off
      wr(`MCP_A_CH0, 32'h0000_000B);
      wr(8'h24, 32'h9);
      wr(8'h28, 32'h4);
      wr(8'h2C, 32'h0002_F002);
      wr(`MCP_A_ENA, 32'h1);
      hold_check();
      wr(`MCP_A_CH0, 32'h0);
      for (i = 0; i < 500; i++) begin
         rd(`MCP_A_ISR, v);
         if (v[0] === 1'b1) break;
      end
      timeout(i);
      for (int k = 0; k < 6; k++) begin
         rd(8'h2C, v);
         chk({31'h0, v <= 32'h9}, 32'h1);
      end
      cyc(40);
      chk(shoot, 32'h0);
      chk({31'h0, gap0 >= 2 && gap0 <= 4}, 32'h1);
      @(posedge clk_i);
      pclk_en_i <= 1'b0;
      cyc(2);
      hold_check();
      @(posedge clk_i);
      pclk_en_i <= 1'b1;
      wr(`MCP_A_CH0, 32'hF);
      cyc(2);
      hold_check();
      wr(`MCP_A_CH0, 32'h0);
      wr(`MCP_A_GRAY, 32'h1);
      wait_gray(2'b00);
      chk({30'h0, gray_o[1:0]}, 32'h1);
      wait_gray(2'b01);
      chk({30'h0, gray_o[1:0]}, 32'h3);
      chk({28'h0, gray_o}, 32'h3);
      wr(`MCP_A_OVR, 32'h0000_0FFF);
      cyc(2);
      chk({24'h0, hi_o, lo_o}, 32'hF0);
      wr(`MCP_A_OVR, 32'h0000_F0FF);
      cyc(2);
      chk({24'h0, hi_o, lo_o}, 32'h0F);
      wr(`MCP_A_IMR, 32'h0);
      wr(`MCP_A_FLT, 32'h0000_0101);
      @(posedge clk_i);
      fault_i <= 4'h1;
      cyc(3);
      chk({24'h0, hi_o, lo_o}, 32'h1E);
      rd(`MCP_A_FLT, v);
      chk({28'h0, v[15:12]}, 32'h1);
      rd(`MCP_A_ISR, v);
      chk({31'h0, v[4]}, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      wr(`MCP_A_IMR, 32'h10);
      cyc(2);
      chk({31'h0, irq_o}, 32'h1);
      @(posedge clk_i);
      fault_i <= 4'h0;
      wr(`MCP_A_ISR, 32'h10);
      cyc(2);
      chk({31'h0, irq_o}, 32'h0);
      // channel 1 follows channel 0 with its own period set to FFFF
      wr(`MCP_A_OVR, 32'h0);
      wr(`MCP_A_FLT, 32'h0);
      wr(8'h34, 32'hFFFF);
      wr(8'h38, 32'h4);
      wr(`MCP_A_SYNC, 32'h2);
      wr(`MCP_A_ENA, 32'h3);
      cyc(10);
      v = rise1;
      cyc(100);
      chk({31'h0, (rise1 - v) >= 5}, 32'h1);
      chk(shoot, 32'h0);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
